// [src/bifc_map.svh]
// Constants for the branch, interrupt and flag control block
`ifndef BIFC_MAP_SVH
`define BIFC_MAP_SVH

// Flag image bit positions, flag-save layout
`define BIFC_CF 0
`define BIFC_PF 2
`define BIFC_AF 4
`define BIFC_ZF 6
`define BIFC_SF 7
`define BIFC_TF 8
`define BIFC_IF 9
`define BIFC_DF 10
`define BIFC_OF 11

// Status bits that the arithmetic unit may write
`define BIFC_ALU_MASK 16'h08d5

// Reset values
`define BIFC_FLAGS_RST 16'h0000
`define BIFC_IP_RST 16'h0000
`define BIFC_CS_RST 16'h0000
`define BIFC_SP_RST 16'h0000
`define BIFC_COUNT_RST 16'h0000

// Stack step, vector table layout and fixed vector types
`define BIFC_STK_STEP 16'h0002
`define BIFC_VEC_CS_OFS 16'h0002
`define BIFC_CNT_STEP 16'h0001
`define BIFC_BRK_TYPE 8'h03
`define BIFC_OVF_TYPE 8'h04
`define BIFC_NMI_TYPE 8'h02

`endif

// [src/bifc_pkg.sv]
// Types for the branch, interrupt and flag control block
package bifc_pkg;

  typedef enum logic [4:0] {
    OP_NOP, OP_JCC, OP_LOOP, OP_LOOPE, OP_LOOPNE, OP_JUMP_COUNT_ZERO,
    OP_INT, OP_INT3, OP_INTO, OP_VECTOR_RETURN_INSTR,
    OP_CLC, OP_CMC, OP_STC, OP_CLD, OP_STD, OP_CLI, OP_STI,
    OP_HLT, OP_WAIT, OP_ESC, OP_LOCK
  } bifc_op_t;

  typedef enum logic [3:0] {
    C_A, C_AE, C_B, C_BE, C_E, C_NE, C_G, C_GE,
    C_L, C_LE, C_O, C_NO, C_P, C_NP, C_S, C_NS
  } bifc_cond_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_PSH_FL = 4'h1, ST_PSH_CS = 4'h3, ST_RD_CS = 4'h2,
    ST_PSH_IP = 4'h6, ST_RD_IP = 4'h7, ST_POP_IP = 4'h5, ST_POP_CS = 4'h4,
    ST_POP_FL = 4'hc, ST_INTA = 4'hd, ST_HALT = 4'hf, ST_WAIT = 4'he
  } bifc_state_t;

endpackage

// [src/bifc_mem_if.sv]
// Request path between the control sequencer and the memory engine
`timescale 1ns/1ps
`default_nettype none
interface bifc_mem_if;
  logic start;
  logic we;
  logic space;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic busy;
  logic done;
  modport ctl (output start, output we, output space, output addr, output wdata,
    input rdata, input busy, input done);
  modport eng (input start, input we, input space, input addr, input wdata,
    output rdata, output busy, output done);
endinterface
`default_nettype wire

// [src/bifc_cond.sv]
// Flag condition evaluator for short conditional jumps
`timescale 1ns/1ps
`default_nettype none
`include "bifc_map.svh"
module bifc_cond
  import bifc_pkg::*;
(
  input wire logic [15:0] flags,
  input wire bifc_cond_t cond,
  output logic taken
);
  logic cf;
  logic zf;
  logic sf;
  logic of;
  logic pf;
  logic lt;

  always_comb
  begin
    cf = flags[`BIFC_CF];
    zf = flags[`BIFC_ZF];
    sf = flags[`BIFC_SF];
    of = flags[`BIFC_OF];
    pf = flags[`BIFC_PF];
    lt = sf ^ of;
    unique case (cond)
      C_A: taken = !(cf | zf);
      C_AE: taken = !cf;
      C_B: taken = cf;
      C_BE: taken = cf | zf;
      C_G: taken = !(lt | zf);
      C_GE: taken = !lt;
      C_L: taken = lt;
      C_LE: taken = lt | zf;
      C_E: taken = zf;
      C_NE: taken = !zf;
      C_O: taken = of;
      C_NO: taken = !of;
      C_P: taken = pf;
      C_NP: taken = !pf;
      C_S: taken = sf;
      C_NS: taken = !sf;
    endcase
  end
endmodule
`default_nettype wire

// [src/bifc_mem.sv]
// Memory engine: one word read or write per start, held until acknowledge
`timescale 1ns/1ps
`default_nettype none
module bifc_mem (
  input wire logic clk,
  input wire logic rst_n,
  bifc_mem_if.eng mif,
  output logic mem_req,
  output logic mem_we,
  output logic mem_space,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack
);
  logic req_q, req_d, we_q, we_d, space_q, space_d;
  logic [15:0] addr_q, addr_d, wdata_q, wdata_d;

  always_comb
  begin
    req_d = req_q;
    we_d = we_q;
    space_d = space_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    if (req_q && mem_ack)
      req_d = 1'b0;
    else if (!req_q && mif.start)
    begin
      req_d = 1'b1;
      we_d = mif.we;
      space_d = mif.space;
      addr_d = mif.addr;
      wdata_d = mif.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_q <= 1'b0;
      we_q <= 1'b0;
      space_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
    end
    else
    begin
      req_q <= req_d;
      we_q <= we_d;
      space_q <= space_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
    end
  end

  assign mif.busy = req_q;
  assign mif.done = req_q && mem_ack;
  assign mif.rdata = mem_rdata;
  assign mem_req = req_q;
  assign mem_we = we_q;
  assign mem_space = space_q;
  assign mem_addr = addr_q;
  assign mem_wdata = wdata_q;
endmodule
`default_nettype wire

// [src/bifc_top.sv]
// Branch, interrupt entry/return and flag control sequencer
`timescale 1ns/1ps
`default_nettype none
`include "bifc_map.svh"
module bifc_top
  import bifc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire bifc_op_t instr_op,
  input wire bifc_cond_t instr_cond,
  input wire logic [7:0] instr_disp,
  input wire logic [7:0] instr_imm,
  input wire logic [15:0] instr_next_ip,
  output logic instr_ready,
  input wire logic alu_flags_we,
  input wire logic [15:0] alu_flags,
  input wire logic count_we,
  input wire logic [15:0] count_in,
  input wire logic sp_we,
  input wire logic [15:0] sp_in,
  input wire logic nmi_req,
  input wire logic maskable_request_line,
  output logic inta_cycle,
  input wire logic inta_ack,
  input wire logic [7:0] inta_type,
  input wire logic test_n,
  output logic halted,
  output logic waiting,
  output logic bus_lock,
  output logic esc_strobe,
  output logic [5:0] coprocessor_handoff,
  output logic [15:0] instruction_pointer,
  output logic [15:0] code_segment,
  output logic [15:0] stack_pointer,
  output logic [15:0] flags,
  output logic [15:0] count_register,
  output logic mem_req,
  output logic mem_we,
  output logic mem_space,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack
);
  logic rst_s1_q, rst_n;
  bifc_state_t state_q, state_d;
  logic [15:0] flags_q, flags_d, ip_q, ip_d, cs_q, cs_d, sp_q, sp_d, count_q, count_d;
  logic [7:0] vtype_q, vtype_d;
  logic shadow_q, shadow_d, nmi_pend_q, nmi_pend_d, nmi_prev_q;
  logic lock_q, lock_d, lock_used_q, lock_used_d, esc_q, esc_d;
  logic [5:0] esc_op_q, esc_op_d;
  logic ready_q, halted_q, waiting_q, inta_q;
  logic accept, cond_taken;
  logic [15:0] disp_ext, br_tgt, count_dec, sp_dec, vec_base;
  bifc_mem_if mif ();

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  bifc_cond u_cond (
    .flags(flags_q),
    .cond(instr_cond),
    .taken(cond_taken)
  );

  bifc_mem u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .mif(mif),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_space(mem_space),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .mem_ack(mem_ack)
  );

  assign accept = instr_valid && ready_q;
  assign disp_ext = {{8{instr_disp[7]}}, instr_disp};
  assign br_tgt = instr_next_ip + disp_ext;
  assign count_dec = count_q - `BIFC_CNT_STEP;
  assign sp_dec = sp_q - `BIFC_STK_STEP;
  assign vec_base = {6'h00, vtype_q, 2'h0};

  always_comb
  begin
    state_d = state_q;
    flags_d = flags_q;
    ip_d = ip_q;
    cs_d = cs_q;
    sp_d = sp_q;
    count_d = count_q;
    vtype_d = vtype_q;
    shadow_d = shadow_q;
    nmi_pend_d = nmi_pend_q;
    lock_d = lock_q;
    lock_used_d = lock_used_q;
    esc_d = 1'b0;
    esc_op_d = esc_op_q;
    mif.start = 1'b0;
    mif.we = 1'b0;
    mif.space = 1'b0;
    mif.addr = 16'h0000;
    mif.wdata = 16'h0000;
    if (alu_flags_we)
      flags_d = (flags_q & ~`BIFC_ALU_MASK) | (alu_flags & `BIFC_ALU_MASK);
    if (count_we)
      count_d = count_in;
    if (sp_we)
      sp_d = sp_in;
    unique case (state_q)
      ST_IDLE:
        if (accept)
        begin
          ip_d = instr_next_ip;
          shadow_d = 1'b0;
          if (lock_q)
            lock_used_d = 1'b1;
          unique case (instr_op)
            OP_JCC: if (cond_taken) ip_d = br_tgt;
            OP_LOOP:
            begin
              count_d = count_dec;
              if (count_dec != 16'h0000) ip_d = br_tgt;
            end
            OP_LOOPE:
            begin
              count_d = count_dec;
              if (count_dec != 16'h0000 && flags_q[`BIFC_ZF]) ip_d = br_tgt;
            end
            OP_LOOPNE:
            begin
              count_d = count_dec;
              if (count_dec != 16'h0000 && !flags_q[`BIFC_ZF]) ip_d = br_tgt;
            end
            OP_JUMP_COUNT_ZERO: if (count_q == 16'h0000) ip_d = br_tgt;
            OP_INT:
            begin
              vtype_d = instr_imm;
              state_d = ST_PSH_FL;
            end
            OP_INT3:
            begin
              vtype_d = `BIFC_BRK_TYPE;
              state_d = ST_PSH_FL;
            end
            OP_INTO:
              if (flags_q[`BIFC_OF])
              begin
                vtype_d = `BIFC_OVF_TYPE;
                state_d = ST_PSH_FL;
              end
            OP_VECTOR_RETURN_INSTR: state_d = ST_POP_IP;
            OP_CLC: flags_d[`BIFC_CF] = 1'b0;
            OP_CMC: flags_d[`BIFC_CF] = !flags_q[`BIFC_CF];
            OP_STC: flags_d[`BIFC_CF] = 1'b1;
            OP_CLD: flags_d[`BIFC_DF] = 1'b0;
            OP_STD: flags_d[`BIFC_DF] = 1'b1;
            OP_CLI: flags_d[`BIFC_IF] = 1'b0;
            OP_STI:
            begin
              flags_d[`BIFC_IF] = 1'b1;
              shadow_d = 1'b1;
            end
            OP_HLT: state_d = ST_HALT;
            OP_WAIT: state_d = ST_WAIT;
            OP_ESC:
            begin
              esc_d = 1'b1;
              esc_op_d = instr_imm[5:0];
            end
            OP_LOCK:
            begin
              lock_d = 1'b1;
              lock_used_d = 1'b0;
            end
            default: ;
          endcase
        end
        else if (nmi_pend_q)
        begin
          nmi_pend_d = 1'b0;
          vtype_d = `BIFC_NMI_TYPE;
          state_d = ST_PSH_FL;
        end
        else if (maskable_request_line && flags_q[`BIFC_IF] && !shadow_q)
          state_d = ST_INTA;
      ST_PSH_FL:
      begin
        mif.start = !mif.busy;
        mif.we = 1'b1;
        mif.addr = sp_dec;
        mif.wdata = flags_q;
        if (mif.done)
        begin
          sp_d = sp_dec;
          flags_d[`BIFC_TF] = 1'b0;
          flags_d[`BIFC_IF] = 1'b0;
          state_d = ST_PSH_CS;
        end
      end
      ST_PSH_CS:
      begin
        mif.start = !mif.busy;
        mif.we = 1'b1;
        mif.addr = sp_dec;
        mif.wdata = cs_q;
        if (mif.done)
        begin
          sp_d = sp_dec;
          state_d = ST_RD_CS;
        end
      end
      ST_RD_CS:
      begin
        mif.start = !mif.busy;
        mif.space = 1'b1;
        mif.addr = vec_base + `BIFC_VEC_CS_OFS;
        if (mif.done)
        begin
          cs_d = mif.rdata;
          state_d = ST_PSH_IP;
        end
      end
      ST_PSH_IP:
      begin
        mif.start = !mif.busy;
        mif.we = 1'b1;
        mif.addr = sp_dec;
        mif.wdata = ip_q;
        if (mif.done)
        begin
          sp_d = sp_dec;
          state_d = ST_RD_IP;
        end
      end
      ST_RD_IP:
      begin
        mif.start = !mif.busy;
        mif.space = 1'b1;
        mif.addr = vec_base;
        if (mif.done)
        begin
          ip_d = mif.rdata;
          state_d = ST_IDLE;
        end
      end
      ST_POP_IP, ST_POP_CS, ST_POP_FL:
      begin
        mif.start = !mif.busy;
        mif.addr = sp_q;
        if (mif.done)
        begin
          sp_d = sp_q + `BIFC_STK_STEP;
          if (state_q == ST_POP_IP)
          begin
            ip_d = mif.rdata;
            state_d = ST_POP_CS;
          end
          else if (state_q == ST_POP_CS)
          begin
            cs_d = mif.rdata;
            state_d = ST_POP_FL;
          end
          else
          begin
            flags_d = mif.rdata;
            state_d = ST_IDLE;
          end
        end
      end
      ST_INTA:
        if (inta_ack)
        begin
          vtype_d = inta_type;
          state_d = ST_PSH_FL;
        end
      ST_HALT:
        if (nmi_pend_q || (maskable_request_line && flags_q[`BIFC_IF]))
          state_d = ST_IDLE;
      ST_WAIT:
        if (!test_n)
          state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
    // A new edge on the non-maskable line wins over the clear above
    if (nmi_req && !nmi_prev_q)
      nmi_pend_d = 1'b1;
    if (lock_used_q && state_d == ST_IDLE)
    begin
      lock_d = 1'b0;
      lock_used_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      flags_q <= `BIFC_FLAGS_RST;
      ip_q <= `BIFC_IP_RST;
      cs_q <= `BIFC_CS_RST;
      sp_q <= `BIFC_SP_RST;
      count_q <= `BIFC_COUNT_RST;
      vtype_q <= 8'h00;
      shadow_q <= 1'b0;
      nmi_pend_q <= 1'b0;
      nmi_prev_q <= 1'b0;
      lock_q <= 1'b0;
      lock_used_q <= 1'b0;
      esc_q <= 1'b0;
      esc_op_q <= 6'h00;
      ready_q <= 1'b0;
      halted_q <= 1'b0;
      waiting_q <= 1'b0;
      inta_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      flags_q <= flags_d;
      ip_q <= ip_d;
      cs_q <= cs_d;
      sp_q <= sp_d;
      count_q <= count_d;
      vtype_q <= vtype_d;
      shadow_q <= shadow_d;
      nmi_pend_q <= nmi_pend_d;
      nmi_prev_q <= nmi_req;
      lock_q <= lock_d;
      lock_used_q <= lock_used_d;
      esc_q <= esc_d;
      esc_op_q <= esc_op_d;
      ready_q <= state_d == ST_IDLE;
      halted_q <= state_d == ST_HALT;
      waiting_q <= state_d == ST_WAIT;
      inta_q <= state_d == ST_INTA;
    end
  end

  assign instr_ready = ready_q;
  assign inta_cycle = inta_q;
  assign halted = halted_q;
  assign waiting = waiting_q;
  assign bus_lock = lock_q;
  assign esc_strobe = esc_q;
  assign coprocessor_handoff = esc_op_q;
  assign instruction_pointer = ip_q;
  assign code_segment = cs_q;
  assign stack_pointer = sp_q;
  assign flags = flags_q;
  assign count_register = count_q;

  property p_above_taken;
    @(posedge clk) disable iff (!rst_n)
    accept && instr_op == OP_JCC && instr_cond == C_A && !flags_q[`BIFC_CF]
      && !flags_q[`BIFC_ZF] |=> ip_q == $past(br_tgt);
  endproperty
  a_above_taken: assert property (p_above_taken) else $error("above jump not taken");

  property p_greater_false;
    @(posedge clk) disable iff (!rst_n)
    accept && instr_op == OP_JCC && instr_cond == C_G
      && ((flags_q[`BIFC_SF] ^ flags_q[`BIFC_OF]) || flags_q[`BIFC_ZF])
      |=> ip_q == $past(instr_next_ip);
  endproperty
  a_greater_false: assert property (p_greater_false) else $error("greater jump wrongly taken");

  property p_parity_even;
    @(posedge clk) disable iff (!rst_n)
    accept && instr_op == OP_JCC && instr_cond == C_P && flags_q[`BIFC_PF]
      |=> ip_q == $past(br_tgt);
  endproperty
  a_parity_even: assert property (p_parity_even) else $error("parity jump not taken");

  property p_loope;
    @(posedge clk) disable iff (!rst_n)
    accept && instr_op == OP_LOOPE |=> count_q == $past(count_dec)
      && ip_q == (($past(count_dec) != 16'h0000 && $past(flags_q[`BIFC_ZF]))
      ? $past(br_tgt) : $past(instr_next_ip));
  endproperty
  a_loope: assert property (p_loope) else $error("loop while equal wrong");

  property p_soft_no_ack;
    @(posedge clk) disable iff (!rst_n)
    accept && (instr_op == OP_INT || instr_op == OP_INT3) |=> !inta_q [*4];
  endproperty
  a_soft_no_ack: assert property (p_soft_no_ack) else $error("acknowledge on soft entry");

  property p_flag_push;
    @(posedge clk) disable iff (!rst_n)
    state_q == ST_PSH_FL && mif.start |=> mem_we && mem_wdata == $past(flags_q)
      && mem_addr == $past(sp_q) - `BIFC_STK_STEP;
  endproperty
  a_flag_push: assert property (p_flag_push) else $error("flag image push wrong");

  property p_vec_ip;
    @(posedge clk) disable iff (!rst_n)
    state_q == ST_RD_IP && mif.start |=> mem_space && mem_addr == {6'h00, vtype_q, 2'h0};
  endproperty
  a_vec_ip: assert property (p_vec_ip) else $error("vector address wrong");

  property p_into_clear;
    @(posedge clk) disable iff (!rst_n)
    accept && instr_op == OP_INTO && !flags_q[`BIFC_OF] |=> state_q == ST_IDLE ##1 !mem_req;
  endproperty
  a_into_clear: assert property (p_into_clear) else $error("overflow trap without overflow");

  property p_clc;
    @(posedge clk) disable iff (!rst_n)
    accept && instr_op == OP_CLC && !alu_flags_we
      |=> flags_q == ($past(flags_q) & ~(16'h0001 << `BIFC_CF));
  endproperty
  a_clc: assert property (p_clc) else $error("carry clear touched other flags");

  property p_halt_nmi;
    @(posedge clk) disable iff (!rst_n)
    state_q == ST_HALT && nmi_pend_q |=> !halted_q;
  endproperty
  a_halt_nmi: assert property (p_halt_nmi) else $error("halt not left on nmi");

  c_soft_entry: cover property (@(posedge clk) disable iff (!rst_n)
    accept && instr_op == OP_INT ##[1:40] state_q == ST_RD_IP && mif.done);
  c_return: cover property (@(posedge clk) disable iff (!rst_n)
    state_q == ST_POP_FL && mif.done);
  c_maskable: cover property (@(posedge clk) disable iff (!rst_n) inta_q && inta_ack);
endmodule
`default_nettype wire

// [verif/bifc_mem_model.sv]
// Memory partner: stack RAM and a patterned vector table, prompt or slow
`timescale 1ns/1ps
`default_nettype none
module bifc_mem_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_space,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  logic [15:0] stk [0:255];
  logic [2:0] wait_q = 3'h0;
  initial
  begin
    mem_ack = 1'b0;
    mem_rdata = 16'h0000;
  end
  // Read data toggles outside the ack cycle so a late sample is seen
  always @(posedge clk)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack)
    begin
      wait_q <= wait_q + 3'h1;
      if (!slow || wait_q == 3'h5)
      begin
        wait_q <= 3'h0;
        mem_ack <= 1'b1;
        if (mem_we)
          stk[mem_addr[8:1]] <= mem_wdata;
        else
          mem_rdata <= mem_space ? {~mem_addr[7:0], mem_addr[7:0]} : stk[mem_addr[8:1]];
      end
    end
  end
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the branch, interrupt and flag control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import bifc_pkg::*;
;
  logic clk = 1'b0, arst_n = 1'b0, instr_valid = 1'b0, alu_flags_we = 1'b0, count_we = 1'b0;
  logic sp_we = 1'b0, nmi_req = 1'b0, maskable_request_line = 1'b0, inta_ack = 1'b0;
  logic test_n = 1'b1, slow = 1'b0, instr_ready, inta_cycle, halted, waiting, bus_lock;
  logic esc_strobe, mem_req, mem_we, mem_space, mem_ack;
  bifc_op_t instr_op = OP_NOP;
  bifc_cond_t instr_cond = C_A;
  logic [7:0] instr_disp = 8'h00, instr_imm = 8'h00, inta_type = 8'h40;
  logic [15:0] instr_next_ip = 16'h1000, alu_flags = 16'h0000, count_in = 16'h0000;
  logic [15:0] sp_in = 16'h0000, instruction_pointer, code_segment, stack_pointer, flags;
  logic [15:0] count_register, mem_addr, mem_wdata, mem_rdata;
  logic [5:0] coprocessor_handoff;
  int failures = 0, n_compared = 0, n_inta = 0;
  logic [15:0] pat[4] = '{16'h0000, 16'h08d5, 16'h0041, 16'h0084};
  bifc_op_t fop[11] = '{OP_STC, OP_CMC, OP_CMC, OP_CLC, OP_STD, OP_STI, OP_CLI, OP_CLD, OP_NOP,
    OP_LOCK, OP_ESC};
  logic [15:0] fex[11] = '{16'h08d5, 16'h08d4, 16'h08d5, 16'h08d4, 16'h0cd4, 16'h0ed4, 16'h0cd4,
    16'h08d4, 16'h08d4, 16'h08d4, 16'h08d4};

  bifc_top dut (.clk, .arst_n, .instr_valid, .instr_op, .instr_cond, .instr_disp, .instr_imm,
    .instr_next_ip, .instr_ready, .alu_flags_we, .alu_flags, .count_we, .count_in, .sp_we,
    .sp_in, .nmi_req, .maskable_request_line, .inta_cycle, .inta_ack, .inta_type, .test_n,
    .halted, .waiting, .bus_lock, .esc_strobe, .coprocessor_handoff, .instruction_pointer,
    .code_segment, .stack_pointer, .flags, .count_register, .mem_req, .mem_we, .mem_space,
    .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
  bifc_mem_model mdl (.clk, .slow, .mem_req, .mem_we, .mem_space, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack);

  always #12.5 clk = ~clk;
  // Acknowledge source answers every acknowledge cycle with a fixed type
  always @(posedge clk)
  begin
    inta_ack <= inta_cycle & ~inta_ack;
    if (inta_cycle && inta_ack)
      n_inta <= n_inta + 1;
  end

  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] vw(logic [15:0] a);
    return {~a[7:0], a[7:0]};
  endfunction

  function automatic logic jt(logic [15:0] f, int c);
    logic [15:0] t;
    logic l;
    l = f[7] ^ f[11];
    t = {~f[7], f[7], ~f[2], f[2], ~f[11], f[11], l | f[6], l, ~l, ~(l | f[6]), ~f[6], f[6],
      f[0] | f[6], f[0], ~f[0], ~(f[0] | f[6])};
    return t[c];
  endfunction

  task automatic rdy;
    int n;
    n = 0;
    do @(negedge clk); while (instr_ready !== 1'b1 && ++n < 400);
  endtask

  task automatic exec(bifc_op_t op, bifc_cond_t c, logic [7:0] d, logic [7:0] im);
    @(posedge clk);
    instr_op <= op;
    instr_cond <= c;
    instr_disp <= d;
    instr_imm <= im;
    instr_valid <= 1'b1;
    rdy();
    @(posedge clk);
    instr_valid <= 1'b0;
    rdy();
  endtask

  task automatic prep(logic [15:0] f, logic [15:0] c, logic [15:0] s);
    @(posedge clk);
    alu_flags_we <= 1'b1;
    alu_flags <= f;
    count_we <= 1'b1;
    count_in <= c;
    sp_we <= 1'b1;
    sp_in <= s;
    @(posedge clk);
    alu_flags_we <= 1'b0;
    count_we <= 1'b0;
    sp_we <= 1'b0;
  endtask

  task automatic tloop(bifc_op_t op, logic [15:0] c, logic [15:0] f, logic tk);
    prep(f, c, 16'h0100);
    exec(op, C_A, 8'h7f, 8'h00);
    chk(instruction_pointer, tk ? 16'h107f : 16'h1000);
    chk(count_register, (op == OP_JUMP_COUNT_ZERO) ? c : c - 16'h0001);
  endtask

  task automatic tint(bifc_op_t op, logic [7:0] im, logic [15:0] v, logic [15:0] f);
    prep(f, 16'h0000, 16'h0100);
    exec(OP_STI, C_A, 8'h00, 8'h00);
    exec(op, C_A, 8'h00, im);
    chk(instruction_pointer, vw(v));
    chk(code_segment, vw(v + 16'h0002));
    chk(stack_pointer, 16'h00fa);
    chk(flags, f);
    chk(mdl.stk[8'h7f], f | 16'h0200);
    chk(mdl.stk[8'h7e], 16'h0000);
    chk(mdl.stk[8'h7d], 16'h1000);
    exec(OP_VECTOR_RETURN_INSTR, C_A, 8'h00, 8'h00);
    chk(instruction_pointer, 16'h1000);
    chk(code_segment, 16'h0000);
    chk(flags, f | 16'h0200);
    chk(stack_pointer, 16'h0100);
  endtask

  task automatic stall(bifc_op_t op);
    fork
      exec(op, C_A, 8'h00, 8'h00);
      begin
        repeat (6) @(negedge clk);
        chk(16'({halted, waiting}), (op == OP_HLT) ? 16'h0002 : 16'h0001);
        @(posedge clk);
        if (op == OP_HLT)
          nmi_req <= 1'b1;
        else
          test_n <= 1'b0;
      end
    join
    // Ready returns one cycle before a pending request starts its entry
    repeat (3) @(negedge clk);
    rdy();
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Tests need about 500 cycles; give up after 20000
  initial
  begin
    #500000;
    failures++;
    wrap_up();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    // Internal reset lingers two edges behind the pin
    repeat (4) @(posedge clk);
    foreach (pat[i])
    begin
      prep(pat[i], 16'h0000, 16'h0100);
      for (int c = 0; c < 16; c++)
      begin
        exec(OP_JCC, bifc_cond_t'(c), 8'h80, 8'h00);
        chk(instruction_pointer, jt(pat[i], c) ? 16'h0f80 : 16'h1000);
      end
    end
    $display("jump test done");
    prep(16'h08d4, 16'h0000, 16'h0100);
    foreach (fop[i])
    begin
      exec(fop[i], C_A, 8'h00, 8'hea);
      chk(flags, fex[i]);
      chk(16'({bus_lock, esc_strobe}), {14'h0000, fop[i] >= OP_ESC, fop[i] == OP_ESC});
    end
    chk(16'(coprocessor_handoff), 16'h002a);
    $display("flag test done");
    tloop(OP_LOOP, 16'h0002, 16'h0000, 1'b1);
    tloop(OP_LOOP, 16'h0001, 16'h0040, 1'b0);
    tloop(OP_LOOPE, 16'h0002, 16'h0040, 1'b1);
    tloop(OP_LOOPE, 16'h0002, 16'h0000, 1'b0);
    tloop(OP_LOOPE, 16'h0001, 16'h0040, 1'b0);
    tloop(OP_LOOPNE, 16'h0000, 16'h0000, 1'b1);
    tloop(OP_LOOPNE, 16'h0002, 16'h0040, 1'b0);
    tloop(OP_JUMP_COUNT_ZERO, 16'h0000, 16'h0040, 1'b1);
    tloop(OP_JUMP_COUNT_ZERO, 16'h0001, 16'h0000, 1'b0);
    $display("loop test done");
    tint(OP_INT, 8'h21, 16'h0084, 16'h0895);
    slow <= 1'b1;
    tint(OP_INT3, 8'h21, 16'h000c, 16'h0040);
    tint(OP_INTO, 8'h00, 16'h0010, 16'h0800);
    prep(16'h0000, 16'h0000, 16'h0100);
    exec(OP_INTO, C_A, 8'h00, 8'h00);
    chk(instruction_pointer, 16'h1000);
    chk(stack_pointer, 16'h0100);
    exec(OP_CLI, C_A, 8'h00, 8'h00);
    @(posedge clk) maskable_request_line <= 1'b1;
    exec(OP_NOP, C_A, 8'h00, 8'h00);
    exec(OP_NOP, C_A, 8'h00, 8'h00);
    chk(16'(n_inta), 16'h0000);
    exec(OP_STI, C_A, 8'h00, 8'h00);
    exec(OP_NOP, C_A, 8'h00, 8'h00);
    repeat (4) @(negedge clk);
    rdy();
    chk(16'(n_inta), 16'h0001);
    chk(instruction_pointer, vw(16'h0100));
    @(posedge clk) maskable_request_line <= 1'b0;
    $display("interrupt test done");
    prep(16'h08d5, 16'h0000, 16'h0100);
    stall(OP_HLT);
    chk(instruction_pointer, vw(16'h0008));
    chk(16'(n_inta), 16'h0001);
    stall(OP_WAIT);
    chk(flags, 16'h08d5);
    $display("halt test done");
    wrap_up();
  end
endmodule
`default_nettype wire
